// *** src/mdc_defines.vh ***
`ifndef MDC_DEFINES_VH
`define MDC_DEFINES_VH
// ****************************************
// Address decode
// ****************************************
`define MDC_CH_MSB 8
`define MDC_CH_LSB 5
`define MDC_IDX_MSB 4
`define MDC_IDX_LSB 2
`define MDC_SHARED_SLOT 4'hF
// ****************************************
// Per-channel register index
// ****************************************
`define MDC_R_CONTROL 3'h0
`define MDC_R_REQSEL 3'h1
`define MDC_R_PSA_HIGH 3'h2
`define MDC_R_PSA_LOW 3'h3
`define MDC_R_SSA_HIGH 3'h4
`define MDC_R_SSA_LOW 3'h5
`define MDC_R_PERIPH 3'h6
`define MDC_R_COUNT 3'h7
// ****************************************
// Shared status register index
// ****************************************
`define MDC_S_LAST_RAM 3'h0
`define MDC_S_WCOL 3'h1
`define MDC_S_RQCOL 3'h2
`define MDC_S_LAST_CH 3'h3
`define MDC_S_BUFSEL 3'h4
// ****************************************
// Field layout
// ****************************************
`define MDC_CTRL_MASK 16'hF833
`define MDC_B_EN 15
`define MDC_B_SIZE 14
`define MDC_B_DIR 13
`define MDC_B_HALF 12
`define MDC_AM_MSB 5
`define MDC_AM_LSB 4
`define MDC_B_PINGPONG 1
`define MDC_B_ONESHOT 0
`define MDC_B_FORCE 15
`define MDC_AM_NOINC 2'h1
`define MDC_AM_PERIPH 2'h2
// ****************************************
// Reset values
// ****************************************
`define MDC_RST16 16'h0000
`define MDC_RST24 24'h00_0000
`define MDC_RST32 32'h0000_0000
`endif

// *** src/mdc_dma.v ***
`timescale 1ns/1ps
`include "mdc_defines.vh"
// Function
// - Up to fifteen channels, each configured separately for its peripheral.
// - Every channel moves data one way; two channels serve both directions.
// - Lowest pending channel number wins; losers stay pending.
// - Block completion raises a per-channel interrupt pulse when the half-block interrupt is not selected.
// - Interrupt selectable at half block or at full block.
// - Post-increment, no-increment, or peripheral-supplied RAM address modes.
// - Element size is byte or 16-bit word.
// - Transfer started by software force or by peripheral request.
// - One-shot stops after a block (in ping-pong, after the secondary buffer's block); continuous restarts blocks.
// - Ping-pong alternates primary and secondary start address per block.
// - Request source chosen from any interrupt source line.
// - RAM accesses use own bus; a ready input lets an arbiter stall.
// - Start address reads return the latest transfer address used, and the start address again once a block completes.
// - 24-bit start addresses split into high 23-16 and low 15-0 registers.
// - Peripheral address is fixed, never incremented.
// - A block completes after count plus one elements.
// - Shared read-only last RAM address, zero at reset.
// - Shared read-only peripheral write collision flag per channel.
// - Shared read-only request collision flag per channel.
// - Read-only number of the most recently active channel.
// - Read-only per-channel ping-pong buffer selection.
// - Force bit not cleared by writing zero to it; hardware, or a control write that disables the channel, clears it.
// - Direction set reads RAM, writes peripheral; clear does the reverse.
module mdc_dma #(
  parameter NCH = 15,
  parameter IRQ_W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [(1<<IRQ_W)-1:0] irq_in,
  input wire [23:0] periph_ram_addr,
  output wire dma_req,
  output wire dma_periph,
  output wire dma_we,
  output wire dma_byte,
  output wire [23:0] dma_addr,
  output wire [15:0] dma_wdata,
  input wire dma_ready,
  input wire [15:0] dma_rdata,
  input wire cpu_periph_wr,
  input wire [15:0] cpu_periph_addr,
  output wire [NCH-1:0] block_irq
);
  localparam S_IDLE = 2'd0;
  localparam S_RD = 2'd1;
  localparam S_WR = 2'd2;

  reg [15:0] ctrl_reg [0:NCH-1];
  reg [IRQ_W-1:0] rsel_reg [0:NCH-1];
  reg [23:0] sta_reg [0:NCH-1];
  reg [23:0] stb_reg [0:NCH-1];
  reg [23:0] la_reg [0:NCH-1];
  reg [23:0] lb_reg [0:NCH-1];
  reg [15:0] pad_reg [0:NCH-1];
  reg [15:0] cnt_reg [0:NCH-1];
  reg [15:0] done_reg [0:NCH-1];
  reg [NCH-1:0] force_reg;
  reg [NCH-1:0] pend_reg;
  reg [NCH-1:0] pp_reg;
  reg [NCH-1:0] rqcol_reg;
  reg [NCH-1:0] wcol_reg;
  reg [NCH-1:0] irq_reg;
  reg [(1<<IRQ_W)-1:0] irq_prev_reg;
  reg [15:0] last_ram_reg;
  reg [3:0] last_ch_reg;
  reg [1:0] state_reg;
  reg [3:0] act_reg;
  reg periph_reg;
  reg we_reg;
  reg byte_reg;
  reg [23:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [31:0] hrdata_reg;
  reg wr_reg;
  reg [3:0] wch_reg;
  reg [2:0] widx_reg;
  reg [15:0] rd_val;
  reg gnt_any;
  reg [3:0] gnt_ch;
  reg [NCH-1:0] kill;
  wire [(1<<IRQ_W)-1:0] rise;
  wire [3:0] rch;
  wire [2:0] ridx;
  wire [23:0] act_ram;
  wire [23:0] gnt_ram;
  wire [15:0] wd;
  integer i;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign dma_req = (state_reg != S_IDLE);
  assign dma_periph = periph_reg;
  assign dma_we = we_reg;
  assign dma_byte = byte_reg;
  assign dma_addr = addr_reg;
  assign dma_wdata = wdata_reg;
  assign block_irq = irq_reg;
  assign rise = irq_in & ~irq_prev_reg;
  assign rch = haddr[`MDC_CH_MSB:`MDC_CH_LSB];
  assign ridx = haddr[`MDC_IDX_MSB:`MDC_IDX_LSB];
  assign wd = hwdata[15:0];

  // ****************************************
  // RAM address of a channel's current element
  // ****************************************
  function [23:0] ram_addr;
    input [3:0] c;
    reg [23:0] base;
    begin
      base = pp_reg[c] ? stb_reg[c] : sta_reg[c];
      case (ctrl_reg[c][`MDC_AM_MSB:`MDC_AM_LSB])
        `MDC_AM_PERIPH: ram_addr = periph_ram_addr;
        `MDC_AM_NOINC: ram_addr = base;
        default: begin
          if (ctrl_reg[c][`MDC_B_SIZE]) begin
            ram_addr = base + {8'h00, done_reg[c]};
          end else begin
            ram_addr = base + {7'h00, done_reg[c], 1'b0};
          end
        end
      endcase
    end
  endfunction

  assign act_ram = ram_addr(act_reg);
  assign gnt_ram = ram_addr(gnt_ch);

  // ****************************************
  // Fixed priority arbiter
  // ****************************************
  always @* begin
    gnt_any = 1'b0;
    gnt_ch = 4'h0;
    // Descending scan so the lowest number wins
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (pend_reg[i] && ctrl_reg[i][`MDC_B_EN]) begin
        gnt_any = 1'b1;
        gnt_ch = i[3:0];
      end
    end
  end

  // A disabling write this cycle blocks a new request
  always @* begin
    kill = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      if (wr_reg && wch_reg == i[3:0] && widx_reg == `MDC_R_CONTROL && !wd[`MDC_B_EN]) begin
        kill[i] = 1'b1;
      end
    end
  end

  // ****************************************
  // Register read mux
  // ****************************************
  always @* begin
    rd_val = `MDC_RST16;
    if (rch == `MDC_SHARED_SLOT) begin
      case (ridx)
        `MDC_S_LAST_RAM: rd_val = last_ram_reg;
        `MDC_S_WCOL: rd_val = {{(16-NCH){1'b0}}, wcol_reg};
        `MDC_S_RQCOL: rd_val = {{(16-NCH){1'b0}}, rqcol_reg};
        `MDC_S_LAST_CH: rd_val = {12'h000, last_ch_reg};
        `MDC_S_BUFSEL: rd_val = {{(16-NCH){1'b0}}, pp_reg};
        default: rd_val = `MDC_RST16;
      endcase
    end else if (rch < NCH) begin
      case (ridx)
        `MDC_R_CONTROL: rd_val = ctrl_reg[rch];
        `MDC_R_REQSEL: rd_val = {force_reg[rch], {(15-IRQ_W){1'b0}}, rsel_reg[rch]};
        `MDC_R_PSA_HIGH: rd_val = {8'h00, la_reg[rch][23:16]};
        `MDC_R_PSA_LOW: rd_val = la_reg[rch][15:0];
        `MDC_R_SSA_HIGH: rd_val = {8'h00, lb_reg[rch][23:16]};
        `MDC_R_SSA_LOW: rd_val = lb_reg[rch][15:0];
        `MDC_R_PERIPH: rd_val = pad_reg[rch];
        `MDC_R_COUNT: rd_val = cnt_reg[rch];
        default: rd_val = `MDC_RST16;
      endcase
    end
  end

  // ****************************************
  // Registers, requests and transfer engine
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < NCH; i = i + 1) begin
        ctrl_reg[i] <= `MDC_RST16;
        rsel_reg[i] <= {IRQ_W{1'b0}};
        sta_reg[i] <= `MDC_RST24;
        stb_reg[i] <= `MDC_RST24;
        la_reg[i] <= `MDC_RST24;
        lb_reg[i] <= `MDC_RST24;
        pad_reg[i] <= `MDC_RST16;
        cnt_reg[i] <= `MDC_RST16;
        done_reg[i] <= `MDC_RST16;
      end
      force_reg <= {NCH{1'b0}};
      pend_reg <= {NCH{1'b0}};
      pp_reg <= {NCH{1'b0}};
      rqcol_reg <= {NCH{1'b0}};
      wcol_reg <= {NCH{1'b0}};
      irq_reg <= {NCH{1'b0}};
      irq_prev_reg <= {(1<<IRQ_W){1'b0}};
      last_ram_reg <= `MDC_RST16;
      last_ch_reg <= 4'h0;
      state_reg <= S_IDLE;
      act_reg <= 4'h0;
      periph_reg <= 1'b0;
      we_reg <= 1'b0;
      byte_reg <= 1'b0;
      addr_reg <= `MDC_RST24;
      wdata_reg <= `MDC_RST16;
      hrdata_reg <= `MDC_RST32;
      wr_reg <= 1'b0;
      wch_reg <= 4'h0;
      widx_reg <= 3'h0;
    end else begin
      irq_reg <= {NCH{1'b0}};
      irq_prev_reg <= irq_in;
      // Address phase capture; zero wait states
      wr_reg <= hsel && htrans[1] && hwrite && hready;
      wch_reg <= rch;
      widx_reg <= ridx;
      if (hsel && htrans[1] && !hwrite && hready) begin
        hrdata_reg <= {16'h0000, rd_val};
      end
      // Data phase write; unmapped slots ignore it
      if (wr_reg && wch_reg < NCH) begin
        case (widx_reg)
          `MDC_R_CONTROL: begin
            ctrl_reg[wch_reg] <= wd & `MDC_CTRL_MASK;
            if (!wd[`MDC_B_EN]) begin
              force_reg[wch_reg] <= 1'b0;
              pend_reg[wch_reg] <= 1'b0;
              rqcol_reg[wch_reg] <= 1'b0;
              wcol_reg[wch_reg] <= 1'b0;
            end
          end
          `MDC_R_REQSEL: begin
            // Writing zero leaves a pending force in place; the set is done below
            rsel_reg[wch_reg] <= wd[IRQ_W-1:0];
          end
          // No guard while enabled; software keeps off these
          `MDC_R_PSA_HIGH: begin
            sta_reg[wch_reg][23:16] <= wd[7:0];
            la_reg[wch_reg][23:16] <= wd[7:0];
          end
          `MDC_R_PSA_LOW: begin
            sta_reg[wch_reg][15:0] <= wd;
            la_reg[wch_reg][15:0] <= wd;
          end
          `MDC_R_SSA_HIGH: begin
            stb_reg[wch_reg][23:16] <= wd[7:0];
            lb_reg[wch_reg][23:16] <= wd[7:0];
          end
          `MDC_R_SSA_LOW: begin
            stb_reg[wch_reg][15:0] <= wd;
            lb_reg[wch_reg][15:0] <= wd;
          end
          `MDC_R_PERIPH: pad_reg[wch_reg] <= wd;
          `MDC_R_COUNT: begin
            cnt_reg[wch_reg] <= wd;
            done_reg[wch_reg] <= `MDC_RST16;
          end
          default: begin
          end
        endcase
      end
      case (state_reg)
        S_IDLE: begin
          if (gnt_any) begin
            act_reg <= gnt_ch;
            byte_reg <= ctrl_reg[gnt_ch][`MDC_B_SIZE];
            we_reg <= 1'b0;
            // Direction picks the source side
            periph_reg <= !ctrl_reg[gnt_ch][`MDC_B_DIR];
            addr_reg <= ctrl_reg[gnt_ch][`MDC_B_DIR] ? gnt_ram : {8'h00, pad_reg[gnt_ch]};
            state_reg <= S_RD;
          end
        end
        S_RD: begin
          // Wait states from the RAM arbiter hold the engine
          if (dma_ready) begin
            wdata_reg <= dma_rdata;
            we_reg <= 1'b1;
            periph_reg <= ctrl_reg[act_reg][`MDC_B_DIR];
            addr_reg <= ctrl_reg[act_reg][`MDC_B_DIR] ? {8'h00, pad_reg[act_reg]} : act_ram;
            if (ctrl_reg[act_reg][`MDC_B_DIR]) begin
              last_ram_reg <= act_ram[15:0];
            end
            state_reg <= S_WR;
          end
        end
        S_WR: begin
          if (periph_reg && cpu_periph_wr && cpu_periph_addr == pad_reg[act_reg]) begin
            wcol_reg[act_reg] <= 1'b1;
          end
          if (dma_ready) begin
            state_reg <= S_IDLE;
            we_reg <= 1'b0;
            last_ch_reg <= act_reg;
            if (!ctrl_reg[act_reg][`MDC_B_DIR]) begin
              last_ram_reg <= act_ram[15:0];
            end
            if (pp_reg[act_reg]) begin
              lb_reg[act_reg] <= act_ram;
            end else begin
              la_reg[act_reg] <= act_ram;
            end
            pend_reg[act_reg] <= 1'b0;
            force_reg[act_reg] <= 1'b0;
            if (ctrl_reg[act_reg][`MDC_B_HALF] && done_reg[act_reg] == (cnt_reg[act_reg] >> 1)) begin
              irq_reg[act_reg] <= 1'b1;
            end
            if (done_reg[act_reg] == cnt_reg[act_reg]) begin
              done_reg[act_reg] <= `MDC_RST16;
              if (!ctrl_reg[act_reg][`MDC_B_HALF]) begin
                irq_reg[act_reg] <= 1'b1;
              end
              if (ctrl_reg[act_reg][`MDC_B_PINGPONG]) begin
                pp_reg[act_reg] <= !pp_reg[act_reg];
                la_reg[act_reg] <= sta_reg[act_reg];
                lb_reg[act_reg] <= stb_reg[act_reg];
              end else if (pp_reg[act_reg]) begin
                lb_reg[act_reg] <= stb_reg[act_reg];
              end else begin
                la_reg[act_reg] <= sta_reg[act_reg];
              end
              // Ping-pong one-shot runs one block per buffer
              if (ctrl_reg[act_reg][`MDC_B_ONESHOT] &&
                  (!ctrl_reg[act_reg][`MDC_B_PINGPONG] || pp_reg[act_reg])) begin
                ctrl_reg[act_reg][`MDC_B_EN] <= 1'b0;
              end
            end else begin
              done_reg[act_reg] <= done_reg[act_reg] + 16'h0001;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      // Requests last so a new one beats the completion clear
      for (i = 0; i < NCH; i = i + 1) begin
        if (ctrl_reg[i][`MDC_B_EN] && !kill[i] && rise[rsel_reg[i]]) begin
          if (pend_reg[i] && !(state_reg == S_WR && dma_ready && act_reg == i[3:0])) begin
            rqcol_reg[i] <= 1'b1;
          end
          pend_reg[i] <= 1'b1;
        end
        // Force set beats a same-cycle completion clear
        if (wr_reg && wch_reg == i[3:0] && widx_reg == `MDC_R_REQSEL && wd[`MDC_B_FORCE] &&
            ctrl_reg[i][`MDC_B_EN]) begin
          force_reg[i] <= 1'b1;
          pend_reg[i] <= 1'b1;
        end
      end
    end
  end
endmodule // mdc_dma

// *** testbench/mdc_dma_chk.sv ***
`timescale 1ns/1ps
module mdc_dma_chk #(
  parameter NCH = 15
) (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire dma_req,
  input wire dma_periph,
  input wire dma_we,
  input wire dma_byte,
  input wire [23:0] dma_addr,
  input wire [15:0] dma_wdata,
  input wire dma_ready,
  input wire [15:0] dma_rdata,
  input wire [NCH-1:0] block_irq
);
  // ****
  // Element handshake properties
  // ****
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire rd_done = dma_req && !dma_we && dma_ready;
  wire wr_done = dma_req && dma_we && dma_ready;
  cpu_no_stall_a: assert property (hreadyout && !hresp)
    else $error("register bus stalled or errored");
  read_then_write_a: assert property (rd_done |=> dma_req && dma_we && dma_periph != $past(dma_periph))
    else $error("write phase missing after read");
  data_carried_a: assert property (rd_done |=> dma_wdata == $past(dma_rdata))
    else $error("write data differs from read data");
  stall_hold_a: assert property (dma_req && !dma_ready |=> dma_req && $stable(dma_addr) && $stable(dma_we))
    else $error("access changed while stalled");
  element_end_a: assert property (wr_done |=> !dma_req)
    else $error("request held after write");
  periph_fixed_a: assert property (dma_req && dma_periph |-> dma_addr[23:16] == 8'h00)
    else $error("peripheral address not zero extended");
  irq_cause_a: assert property (|block_irq |-> $past(wr_done))
    else $error("block pulse without element end");
  irq_pulse_a: assert property (|block_irq |-> $onehot(block_irq) ##1 !(|block_irq))
    else $error("block pulse too wide");
  size_hold_a: assert property (dma_req && dma_we |-> $stable(dma_byte))
    else $error("element size changed mid element");
  cover property (wr_done && dma_byte);
  cover property (|block_irq);
  cover property (dma_req && !dma_ready);
endmodule // mdc_dma_chk
bind mdc_dma mdc_dma_chk #(.NCH(NCH)) i_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .dma_req(dma_req), .dma_periph(dma_periph), .dma_we(dma_we), .dma_byte(dma_byte),
  .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ready(dma_ready), .dma_rdata(dma_rdata),
  .block_irq(block_irq));

// *** testbench/mdc_far.sv ***
`timescale 1ns/1ps
module mdc_far (
  input wire hclk,
  input wire hresetn,
  input wire slow,
  input wire dma_req,
  input wire dma_we,
  input wire [23:0] dma_addr,
  output wire dma_ready,
  output wire [15:0] dma_rdata
);
  reg [1:0] wait_reg;
  reg [15:0] last_reg;
  // Slow mode holds off three cycles, as a busy arbiter would
  assign dma_ready = dma_req && (!slow || wait_reg == 2'h3);
  // Idle bus shows the inverse of the last word, never a stale copy
  assign dma_rdata = (dma_req && !dma_we) ? dma_addr[15:0] ^ 16'h5a5a : ~last_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_reg <= 2'h0;
      last_reg <= 16'h0000;
    end else begin
      wait_reg <= (dma_req && !dma_ready) ? wait_reg + 2'h1 : 2'h0;
      if (dma_req && !dma_we && dma_ready) last_reg <= dma_rdata;
    end
  end
endmodule // mdc_far

// *** testbench/test_multichannel_dma_controller.sv ***
`timescale 1ns/1ps
module test_multichannel_dma_controller;
  reg hclk, hresetn, hsel, hwrite, dma_slow, cpu_periph_wr, bt;
  reg [31:0] haddr, hwdata;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [255:0] irq_in;
  reg [23:0] periph_ram_addr, wa, ra;
  reg [15:0] cpu_periph_addr;
  reg [14:0] irq_seen;
  wire hready, hresp, dma_req, dma_periph, dma_we, dma_byte, dma_ready;
  wire [31:0] hrdata;
  wire [23:0] dma_addr;
  wire [15:0] dma_wdata, dma_rdata;
  wire [14:0] block_irq;
  int n_fail, n_compared, n_el, n_irq;
  mdc_dma #(.NCH(15), .IRQ_W(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .irq_in(irq_in), .periph_ram_addr(periph_ram_addr), .dma_req(dma_req),
    .dma_periph(dma_periph), .dma_we(dma_we), .dma_byte(dma_byte), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
    .dma_ready(dma_ready), .dma_rdata(dma_rdata), .cpu_periph_wr(cpu_periph_wr),
    .cpu_periph_addr(cpu_periph_addr), .block_irq(block_irq));
  mdc_far i_far (.hclk(hclk), .hresetn(hresetn), .slow(dma_slow), .dma_req(dma_req), .dma_we(dma_we),
    .dma_addr(dma_addr), .dma_ready(dma_ready), .dma_rdata(dma_rdata));
  // ****
  // Observers and bus tasks
  // ****
  always @(posedge hclk) begin
    irq_seen <= irq_seen | block_irq;
    n_irq <= n_irq + (block_irq != 15'h0000);
    if (dma_req && dma_ready && dma_we) begin
      n_el <= n_el + 1;
      wa <= dma_addr;
      bt <= dma_byte;
    end
    if (dma_req && dma_ready && !dma_we) ra <= dma_addr;
  end
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task stop_test;
    begin
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [23:0] s, input [23:0] e);
    begin
      n_compared++;
      if (s !== e) begin
        n_fail++;
        $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task rdy_wait;
    int k;
    begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (hready !== 1'b1 && k < 16);
      if (hready !== 1'b1) begin
        n_fail++;
        stop_test;
      end
    end
  endtask
  task xfer(input w, input [3:0] c, input [2:0] i, input [15:0] d, output [15:0] q);
    begin
      hsel <= 1'b1;
      haddr <= {23'h00_0000, c, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      rdy_wait;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0000, d};
      rdy_wait;
      q = hrdata[15:0];
    end
  endtask
  task wr(input [3:0] c, input [2:0] i, input [15:0] d);
    reg [15:0] q;
    xfer(1'b1, c, i, d, q);
  endtask
  task rc(input string nm, input [3:0] c, input [2:0] i, input [23:0] e);
    reg [15:0] q;
    begin
      xfer(1'b0, c, i, 16'h0000, q);
      chk(nm, {8'h00, q}, e);
    end
  endtask
  task pulse(input [7:0] s);
    begin
      irq_in[s] <= 1'b1;
      @(posedge hclk);
      irq_in[s] <= 1'b0;
      @(posedge hclk);
    end
  endtask
  // Extra edge lets the block pulse land in the counter
  task wait_el(input int n);
    int k;
    begin
      k = 0;
      while (n_el < n && k < 200) begin
        @(posedge hclk);
        #1;
        k++;
      end
      if (n_el < n) begin
        n_fail++;
        stop_test;
      end
      @(posedge hclk);
      #1;
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {hresetn, hsel, hwrite, dma_slow, cpu_periph_wr} = 5'h00;
    {haddr, hwdata} = 64'h0000_0000_0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    irq_in = {256{1'b0}};
    periph_ram_addr = 24'h00_abcd;
    cpu_periph_addr = 16'h0000;
    irq_seen = 15'h0000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("last ram", 4'hf, 3'h0, 24'h00_0000);
    wr(4'hf, 3'h0, 16'hffff);
    rc("last ram ro", 4'hf, 3'h0, 24'h00_0000);
    rc("unmapped", 4'hf, 3'h5, 24'h00_0000);
    wr(1, 2, 16'h0012);
    wr(1, 3, 16'h0100);
    wr(1, 6, 16'h0800);
    wr(1, 7, 16'h0002);
    wr(1, 1, 16'h0005);
    wr(1, 0, 16'h8001);
    pulse(5);
    wait_el(1);
    chk("ch1 src", ra, 24'h00_0800);
    chk("ch1 dst0", wa, 24'h12_0100);
    pulse(5);
    wait_el(2);
    chk("ch1 dst1", wa, 24'h12_0102);
    rc("ch1 sta low mid", 1, 3, 24'h00_0102);
    chk("irq early", n_irq, 24'h00_0000);
    pulse(5);
    wait_el(3);
    chk("irq full", n_irq, 24'h00_0001);
    rc("last ram", 4'hf, 3'h0, 24'h00_0104);
    rc("last ch", 4'hf, 3'h3, 24'h00_0001);
    rc("ch1 sta high", 1, 2, 24'h00_0012);
    rc("ch1 sta low", 1, 3, 24'h00_0100);
    rc("ch1 ctrl", 1, 0, 24'h00_0001);
    pulse(5);
    repeat (8) @(posedge hclk);
    chk("one shot", n_el, 24'h00_0003);
    wr(2, 6, 16'h0900);
    wr(2, 7, 16'h0000);
    wr(2, 1, 16'h0007);
    wr(2, 0, 16'ha021);
    wr(3, 2, 16'h0000);
    wr(3, 3, 16'h0300);
    wr(3, 6, 16'h0a00);
    wr(3, 7, 16'h0001);
    wr(3, 1, 16'h0007);
    wr(3, 0, 16'hd011);
    cpu_periph_wr <= 1'b1;
    cpu_periph_addr <= 16'h0900;
    dma_slow <= 1'b1;
    pulse(7);
    wait_el(4);
    chk("ch2 src", ra, 24'h00_abcd);
    chk("ch2 dst", wa, 24'h00_0900);
    chk("ch2 word", bt, 1'b0);
    wait_el(5);
    chk("ch3 dst", wa, 24'h00_0300);
    chk("ch3 byte", bt, 1'b1);
    chk("irq half", n_irq, 24'h00_0003);
    pulse(7);
    wait_el(6);
    chk("ch3 noinc", wa, 24'h00_0300);
    chk("no full irq", n_irq, 24'h00_0003);
    rc("wr coll", 4'hf, 3'h1, 24'h00_0004);
    cpu_periph_wr <= 1'b0;
    dma_slow <= 1'b0;
    wr(4, 3, 16'h0400);
    wr(4, 5, 16'h0500);
    wr(4, 6, 16'h0c00);
    wr(4, 7, 16'h0000);
    wr(4, 0, 16'h8003);
    wr(4, 1, 16'h8000);
    wait_el(7);
    chk("ping", wa, 24'h00_0400);
    rc("force clr", 4, 1, 24'h00_0000);
    rc("bufsel b", 4'hf, 3'h4, 24'h00_0010);
    wr(4, 1, 16'h8000);
    wait_el(8);
    chk("pong", wa, 24'h00_0500);
    rc("bufsel a", 4'hf, 3'h4, 24'h00_0000);
    rc("ch4 ctrl", 4, 0, 24'h00_0003);
    chk("irq chans", irq_seen, 24'h00_001e);
    // Continuous channel; second request lands while the first is still pending
    wr(5, 1, 16'h0009);
    wr(5, 0, 16'h8000);
    pulse(9);
    pulse(9);
    wait_el(9);
    rc("req coll", 4'hf, 3'h2, 24'h00_0020);
    rc("ch5 repeat", 5, 0, 24'h00_8000);
    chk("one element", n_el, 24'h00_0009);
    wr(5, 0, 16'h0000);
    rc("req coll clr", 4'hf, 3'h2, 24'h00_0000);
    stop_test;
  end
endmodule // test_multichannel_dma_controller
